/* rtl/pld_pkg.sv */
// Purpose: constants for the pulse-count LED dimmer
// Assumes: mclk at 50 MHz
// Notes: times kept in ns, counts derived from the clock period
package pld_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // deglitch: pulses shorter than this are rejected
    localparam int GLITCH_NS = 200;
    localparam int GLITCH_CYC = GLITCH_NS / CLK_PERIOD_NS;
    // shutdown delay: beyond the 500 us longest low phase
    localparam int SHUT_NS = 800000;
    localparam int SHUT_CYC = SHUT_NS / CLK_PERIOD_NS;
    localparam int CODE_W = 4;
    localparam int CHAN_N = 4;
    localparam logic [3:0] CODE_FULL = 4'h0;
    localparam logic [3:0] CODE_RESET = 4'h0;
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_LOW} pld_state_type;
endpackage : pld_pkg

/* rtl/pld_deglitch.sv */
// Purpose: deglitch filter for the dim control input
// Assumes: input synchronous to mclk
// Notes: output follows input only after a stable run of CYC cycles
`timescale 1ns/1ns
`default_nettype none
module pld_deglitch #(
    parameter int CYC = 10
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic rawIn,
    output logic cleanOut
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic clean_r;
    logic clean_nxt;

    always_comb
    begin
        cnt_nxt = 16'h0000;
        clean_nxt = clean_r;
        if (rawIn != clean_r)
        begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r == 16'(CYC - 1))
            begin
                clean_nxt = rawIn;
                cnt_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 16'h0000;
            clean_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            clean_r <= clean_nxt;
        end
    end

    assign cleanOut = clean_r;
endmodule : pld_deglitch
`default_nettype wire

/* rtl/pld_dimmer.sv */
// Purpose: pulse-counting brightness control for a 4-channel LED sink
// Assumes: dimIn, tempHigh and tempLow synchronous to mclk
// Notes: levelCode 0 = 20 mA, each step 1.25 mA lower, 15 = 1.25 mA
// Notes: tempHigh and tempLow come from external hysteresis comparators
//
// Operation
// - Device works while dim input is high; a low longer than the shutdown delay disables it.
// - One 4-bit code sets sixteen current levels for all four channels.
// - First rising edge gives 20 mA; each further edge lowers 1.25 mA, and from 1.25 mA wraps to 20 mA.
// - Selected current stays constant, unmodulated, while input high.
// - Filter input so short spikes are neither edges nor enable.
// - Over-temperature above 145 C cuts outputs; restored below 125 C.
`timescale 1ns/1ns
`default_nettype none
module pld_dimmer
    import pld_pkg::*;
#(
    parameter int SHUT_COUNT = SHUT_CYC,
    parameter int GLITCH_COUNT = GLITCH_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dimIn,
    input wire logic tempHigh,
    input wire logic tempLow,
    output logic [pld_pkg::CODE_W-1:0] levelCode,
    output logic [pld_pkg::CHAN_N-1:0] chanEnable,
    output logic thermalOff,
    output logic active
);
    import pld_pkg::*;

    // ****************************************
    // input filter
    // ****************************************
    logic dimClean;

    pld_deglitch #(
        .CYC(GLITCH_COUNT)
    ) uFilter (
        .mclk(mclk),
        .rst_n(rst_n),
        .rawIn(dimIn),
        .cleanOut(dimClean)
    );

    // ****************************************
    // step state
    // ****************************************
    pld_state_type state_r;
    pld_state_type state_nxt;
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [22:0] low_r;
    logic [22:0] low_nxt;
    logic lowDone;
    logic stepRise;
    logic hot_r;
    logic hot_nxt;
    logic [CHAN_N-1:0] en_r;
    logic [CHAN_N-1:0] en_nxt;

    always_comb
    begin
        state_nxt = state_r;
        stepRise = 1'b0;
        case (state_r)
            ST_OFF:
            begin
                if (dimClean)
                begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON:
            begin
                if (!dimClean)
                begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (dimClean)
                begin
                    state_nxt = ST_ON;
                    stepRise = 1'b1;
                end
                else if (lowDone)
                begin
                    state_nxt = ST_OFF;
                end
            end
            default:
            begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_OFF;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // shutdown timer
    // ****************************************
    // runs only in a low phase, so every new low starts from zero
    always_comb
    begin
        low_nxt = 23'h000000;
        lowDone = 1'b0;
        if (state_r == ST_LOW)
        begin
            low_nxt = low_r + 23'h000001;
            if (low_r == 23'(SHUT_COUNT - 1))
            begin
                lowDone = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_r <= 23'h000000;
        end
        else
        begin
            low_r <= low_nxt;
        end
    end

    // ****************************************
    // brightness code
    // ****************************************
    // 4-bit add rolls 15 over to 0: the wrap back to full current
    always_comb
    begin
        code_nxt = code_r;
        if (state_nxt == ST_OFF)
        begin
            code_nxt = CODE_RESET;
        end
        else if (state_r == ST_OFF)
        begin
            code_nxt = CODE_FULL;
        end
        else if (stepRise)
        begin
            code_nxt = code_r + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_r <= CODE_RESET;
        end
        else
        begin
            code_r <= code_nxt;
        end
    end

    // ****************************************
    // thermal hysteresis
    // ****************************************
    // a hot reading wins over a cool one in the same cycle
    always_comb
    begin
        hot_nxt = hot_r;
        if (tempHigh)
        begin
            hot_nxt = 1'b1;
        end
        else if (tempLow)
        begin
            hot_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hot_r <= 1'b0;
        end
        else
        begin
            hot_r <= hot_nxt;
        end
    end

    // ****************************************
    // channel enables
    // ****************************************
    // held through low phases: no modulation while high
    always_comb
    begin
        en_nxt = {CHAN_N{1'b0}};
        if (state_nxt != ST_OFF && !hot_nxt)
        begin
            en_nxt = {CHAN_N{1'b1}};
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_r <= {CHAN_N{1'b0}};
        end
        else
        begin
            en_r <= en_nxt;
        end
    end

    assign levelCode = code_r;
    assign chanEnable = en_r;
    assign thermalOff = hot_r;
    assign active = (state_r != ST_OFF);
endmodule : pld_dimmer
`default_nettype wire

/* bench/pld_dimmer_chk.sv */
// Purpose: dimmer port checks
// Assumes: G, S match the instance
// Notes: run counts cycles since dimIn moved
`timescale 1ns/1ns
`default_nettype none
module pld_dimmer_chk #(
    parameter int G = 10,
    parameter int S = 40000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dimIn,
    input wire logic tempHigh,
    input wire logic tempLow,
    input wire logic [3:0] levelCode,
    input wire logic [3:0] chanEnable,
    input wire logic thermalOff,
    input wire logic active
);
    int run;
    logic last;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last <= 1'b0;
            run <= 0;
        end
        else
        begin
            last <= dimIn;
            run <= (dimIn != last) ? 0 : run + 1;
        end
    end
    sequence s_code_top;
        active && levelCode == 4'hF;
    endsequence
    sequence s_code_moved;
        $changed(levelCode);
    endsequence
    a_wrap_full:
        assert property (s_code_top ##1 s_code_moved |-> levelCode == 4'h0)
        else $error("wrap");
    a_code_step:
        assert property (active && $changed(levelCode) |->
            levelCode == $past(levelCode) + 4'h1) else $error("step");
    a_first_full:
        assert property ($rose(active) |-> levelCode == 4'h0 && run >= G - 1)
        else $error("first");
    a_dark_off:
        assert property (!active |-> chanEnable == 4'h0) else $error("dark");
    a_full_on:
        assert property (active && !thermalOff |-> chanEnable == 4'hF)
        else $error("on");
    a_heat_cut:
        assert property (tempHigh |=> thermalOff && chanEnable == 4'h0)
        else $error("hot");
    a_heat_back:
        assert property (thermalOff && tempLow && !tempHigh |=> !thermalOff)
        else $error("cool");
    a_hold_const:
        assert property (dimIn && run > G + 1 |-> $stable(levelCode))
        else $error("hold");
    a_shut_late:
        assert property ($fell(active) |-> !dimIn && run >= S + G - 1)
        else $error("shut");
endmodule : pld_dimmer_chk
bind pld_dimmer pld_dimmer_chk #(.G(GLITCH_COUNT), .S(SHUT_COUNT)) uChk (
    .mclk, .rst_n, .dimIn, .tempHigh, .tempLow, .levelCode, .chanEnable,
    .thermalOff, .active);
`default_nettype wire

/* bench/pld_host.sv */
// Purpose: host GPIO on dimIn
// Assumes: 26 cycles just over 0.5 us
// Notes: low is the pulled-down idle
`timescale 1ns/1ns
`default_nettype none
module pld_host (
    input wire logic mclk,
    output logic dimIn
);
    initial dimIn = 1'b0;
    task automatic drive(input logic v, input int n);
        @(posedge mclk);
        dimIn <= v;
        repeat (n - 1) @(posedge mclk);
    endtask : drive
    task automatic step();
        drive(1'b0, 26);
        drive(1'b1, 26);
    endtask : step
endmodule : pld_host
`default_nettype wire

/* bench/pld_dimmer_bench.sv */
// Purpose: dimmer bench
// Assumes: G=3, S=50
// Notes: host model drives dimIn
`timescale 1ns/1ns
`default_nettype none
module pld_dimmer_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic tempHigh = 1'b0;
    logic tempLow = 1'b1;
    logic dimIn;
    logic [3:0] levelCode;
    logic [3:0] chanEnable;
    logic thermalOff;
    logic active;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    initial forever #10 mclk = ~mclk;
    pld_host host (.mclk, .dimIn);
    pld_dimmer #(.SHUT_COUNT(50), .GLITCH_COUNT(3)) DUT (.mclk, .rst_n,
        .dimIn, .tempHigh, .tempLow, .levelCode, .chanEnable, .thermalOff,
        .active);
    task automatic chk(input logic ok);
        n_tests++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("BAD %0t check %0d", $time, n_tests);
        end
    endtask : chk
    task automatic close_out();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic t_steps();
        host.drive(1'b1, 1001);
        @(negedge mclk);
        chk(active === 1'b1 && levelCode === 4'h0);
        for (int i = 1; i <= 17; i++)
        begin
            host.step();
            @(negedge mclk);
            chk(levelCode === 4'(i) && chanEnable === 4'hF);
        end
        host.drive(1'b0, 2);
        host.drive(1'b1, 20);
        @(negedge mclk);
        chk(levelCode === 4'h1);
    endtask : t_steps
    task automatic t_heat();
        @(posedge mclk);
        tempHigh <= 1'b1;
        tempLow <= 1'b0;
        @(posedge mclk);
        tempHigh <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk(thermalOff === 1'b1 && chanEnable === 4'h0);
        @(posedge mclk);
        tempLow <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(thermalOff === 1'b0 && chanEnable === 4'hF);
    endtask : t_heat
    task automatic t_shut();
        host.drive(1'b0, 30);
        @(negedge mclk);
        chk(active === 1'b1 && chanEnable === 4'hF);
        host.drive(1'b0, 30);
        @(negedge mclk);
        chk(active === 1'b0 && levelCode === 4'h0);
        host.drive(1'b1, 2);
        host.drive(1'b0, 10);
        @(negedge mclk);
        chk(active === 1'b0 && chanEnable === 4'h0);
    endtask : t_shut
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            close_out();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_steps();
        t_heat();
        t_shut();
        close_out();
    end
endmodule : pld_dimmer_bench
`default_nettype wire
